//--- common/sfl_regs.vh
// register map, field positions and reset values of the fifo level block
`ifndef SFL_REGS_VH
`define SFL_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SFL_STATUS_OFS  8'h10
`define SFL_COUNT_OFS   8'h14
`define SFL_MASK_OFS    8'h18
`define SFL_TRIG_OFS    8'h1C
`define SFL_TXDATA_OFS  8'h20
`define SFL_RXDATA_OFS  8'h24

// ----------------------------------------------------------------
// status and mask bit positions
// ----------------------------------------------------------------
`define SFL_B_XFER_DONE 0
`define SFL_B_DMA_DONE  1
`define SFL_B_TX_OVF    2
`define SFL_B_RX_UDF    3
`define SFL_B_PROG_ERR  4
`define SFL_B_TX_FULL   8
`define SFL_B_TX_EMPTY  9
`define SFL_B_TX_REQ    10
`define SFL_B_RX_FULL   12
`define SFL_B_RX_EMPTY  13
`define SFL_B_RX_REQ    14

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define SFL_RX_FLD      31:16
`define SFL_TX_FLD      15:0
`define SFL_MASK_RW     32'h0000771F
`define SFL_MASK_RST    32'h00002000
`define SFL_TRIG_RST    32'h00000000
`define SFL_CNT_RST     16'h0000

`endif

//--- hw/sfl_top.v
// apb register slice: fifo byte counts, interrupt mask, level triggers, tx port
`timescale 1ns/1ps
`include "sfl_regs.vh"

// Functional notes
// - count bits 31:16 give rx bytes
// - count bits 15:0 give tx bytes
// - rx empty enable bit 13 resets to one
// - rx request bit 14, rx full bit 12
// - tx request 10, empty 9, full 8
// - prog_err_ie at bit 4
// - rx underflow bit 3, tx overflow bit 2
// - dma finished enable at bit 1
// - transfer finished enable at bit 0
// - rx request when count reaches rx threshold
// - tx request when count at or below threshold
// - zero threshold disables level request, resets zero
// - byte, halfword, word enqueue 1, 2, 4
// - write to full tx fifo flags overflow
// - tx count rises by bytes enqueued
// - errors sticky until written one
module sfl_top #(
  parameter AW = 4
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        tx_pop,
  output wire [7:0]  tx_byte,
  output wire        tx_byte_vld,
  input  wire        rx_push,
  input  wire [7:0]  rx_byte,
  input  wire        xfer_done,
  input  wire        dma_done,
  input  wire        prog_err_flag,
  output wire        irq
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  localparam [15:0] DEPTH = 16'd1 << AW;

  reg  [7:0]    tx_mem [0:(1<<AW)-1];
  reg  [7:0]    rx_mem [0:(1<<AW)-1];
  reg  [AW-1:0] tx_wp_reg;
  reg  [AW-1:0] tx_rp_reg;
  reg  [AW-1:0] rx_wp_reg;
  reg  [AW-1:0] rx_rp_reg;
  reg  [15:0]   tx_cnt_reg;
  reg  [15:0]   rx_cnt_reg;
  reg  [15:0]   tx_cnt_next;
  reg  [15:0]   rx_cnt_next;
  reg  [31:0]   mask_reg;
  reg  [31:0]   trig_reg;
  reg  [4:0]    st_reg;
  reg  [4:0]    st_next;
  reg  [31:0]   prdata_reg;
  reg           pready_reg;
  reg           pslverr_reg;
  reg  [7:0]    tx_byte_reg;
  reg           tx_vld_reg;
  reg           irq_reg;
  reg  [31:0]   rd_mux;
  reg           rd_err;
  integer       i;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // access phase ends on the cycle after it starts
  wire        done    = psel & penable & pready_reg;
  wire        wr      = done & pwrite;
  wire        rd      = done & ~pwrite;
  wire        a_stat  = (paddr == `SFL_STATUS_OFS);
  wire        a_cnt   = (paddr == `SFL_COUNT_OFS);
  wire        a_mask  = (paddr == `SFL_MASK_OFS);
  wire        a_trig  = (paddr == `SFL_TRIG_OFS);
  wire        a_tx    = (paddr == `SFL_TXDATA_OFS);
  wire        a_rx    = (paddr == `SFL_RXDATA_OFS);
  wire        mapped  = a_stat | a_cnt | a_mask | a_trig | a_tx | a_rx;

  // bytes in a tx write; no strobes at all counts as a word
  wire [3:0]  strb    = (pstrb == 4'h0) ? 4'hF : pstrb;
  wire [2:0]  nbytes  = {2'b00, strb[0]} + {2'b00, strb[1]}
                      + {2'b00, strb[2]} + {2'b00, strb[3]};
  // byte count widened so any pointer width can take its low bits
  wire [AW+2:0] nb_wide = {{AW{1'b0}}, nbytes};
  wire [15:0] tx_free = DEPTH - tx_cnt_reg;

  // ----------------------------------------------------------------
  // fifo events
  // ----------------------------------------------------------------
  // a write that does not fit is dropped whole, never split, so the
  // engine never shifts out part of a word
  wire        tx_wr   = wr & a_tx;
  wire        tx_fits = (tx_free >= {13'h0000, nbytes});
  wire        tx_push = tx_wr & tx_fits;
  wire        tx_ovf  = tx_wr & ~tx_fits;
  wire        tx_take = tx_pop & (tx_cnt_reg != 16'h0000);
  wire        rx_full = (rx_cnt_reg == DEPTH);
  wire        rx_emp  = (rx_cnt_reg == 16'h0000);
  wire        rx_put  = rx_push & ~rx_full;
  wire        rx_take = rd & a_rx & ~rx_emp;
  wire        rx_udf  = rd & a_rx & rx_emp;

  // ----------------------------------------------------------------
  // live level flags
  // ----------------------------------------------------------------
  wire        tx_full = (tx_cnt_reg == DEPTH);
  wire        tx_emp  = (tx_cnt_reg == 16'h0000);
  wire [15:0] rx_trig = trig_reg[`SFL_RX_FLD];
  wire [15:0] tx_trig = trig_reg[`SFL_TX_FLD];
  wire        rx_req  = (rx_trig != 16'h0000)
                      & (rx_cnt_reg >= rx_trig);
  wire        tx_req  = (tx_trig != 16'h0000)
                      & (tx_cnt_reg <= tx_trig);

  // status word seen by software and by the interrupt gate
  wire [31:0] status  = {17'h00000, rx_req, rx_emp, rx_full, 1'b0,
                         tx_req, tx_emp, tx_full, 3'b000, st_reg};

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  // counts move by pushes minus pops in the same cycle
  always @* begin
    tx_cnt_next = tx_cnt_reg;
    if (tx_push)
      tx_cnt_next = tx_cnt_next + {13'h0000, nbytes};
    if (tx_take)
      tx_cnt_next = tx_cnt_next - 16'h0001;
    rx_cnt_next = rx_cnt_reg;
    if (rx_put)
      rx_cnt_next = rx_cnt_next + 16'h0001;
    if (rx_take)
      rx_cnt_next = rx_cnt_next - 16'h0001;
  end

  // sticky flags: write one clears, a new event in the same cycle wins
  always @* begin
    st_next = st_reg;
    if (wr & a_stat)
      st_next = st_next & ~pwdata[4:0];
    if (xfer_done)
      st_next[`SFL_B_XFER_DONE] = 1'b1;
    if (dma_done)
      st_next[`SFL_B_DMA_DONE] = 1'b1;
    if (tx_ovf)
      st_next[`SFL_B_TX_OVF] = 1'b1;
    if (rx_udf)
      st_next[`SFL_B_RX_UDF] = 1'b1;
    if (prog_err_flag)
      st_next[`SFL_B_PROG_ERR] = 1'b1;
  end

  // read data mux, unmapped offsets answer with an error
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = ~mapped;
    case (1'b1)
      a_stat:  rd_mux = status;
      a_cnt:   rd_mux = {rx_cnt_reg, tx_cnt_reg};
      a_mask:  rd_mux = mask_reg;
      a_trig:  rd_mux = trig_reg;
      a_rx:    rd_mux = rx_emp ? 32'h00000000 : {24'h000000, rx_mem[rx_rp_reg]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // apb response
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle, and read
  // data and the error answer are captured at the same edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      pready_reg  <= psel & penable & ~pready_reg;
      if (psel & penable & ~pready_reg) begin
        prdata_reg  <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_reg <= rd_err;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // mask bits 14,13,12,10,9,8,4..0 only; the rest stay zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg    <= `SFL_MASK_RST;
      trig_reg    <= `SFL_TRIG_RST;
    end else if (ce) begin
      if (wr & a_mask)
        mask_reg <= pwdata & `SFL_MASK_RW;
      // both thresholds are plain storage; the compares sit above
      if (wr & a_trig)
        trig_reg <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // tx fifo pointers and output byte
  // ----------------------------------------------------------------
  // write pointer advances by the enqueued bytes, read pointer by one;
  // the popped byte stands until the next pop, valid for one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_reg   <= {AW{1'b0}};
      tx_rp_reg   <= {AW{1'b0}};
      tx_byte_reg <= 8'h00;
      tx_vld_reg  <= 1'b0;
    end else if (ce) begin
      if (tx_push)
        tx_wp_reg <= tx_wp_reg + nb_wide[AW-1:0];
      if (tx_take)
        tx_rp_reg <= tx_rp_reg + {{(AW-1){1'b0}}, 1'b1};
      tx_byte_reg <= tx_take ? tx_mem[tx_rp_reg] : tx_byte_reg;
      tx_vld_reg  <= tx_take;
    end
  end

  // ----------------------------------------------------------------
  // rx fifo pointers
  // ----------------------------------------------------------------
  // a push into a full fifo or a read of an empty one moves nothing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_wp_reg   <= {AW{1'b0}};
      rx_rp_reg   <= {AW{1'b0}};
    end else if (ce) begin
      if (rx_put)
        rx_wp_reg <= rx_wp_reg + {{(AW-1){1'b0}}, 1'b1};
      if (rx_take)
        rx_rp_reg <= rx_rp_reg + {{(AW-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // counts, sticky status and interrupt
  // ----------------------------------------------------------------
  // irq is registered from the live status, one cycle behind its cause,
  // so a glitch on the combined flags never reaches the pin
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_reg  <= `SFL_CNT_RST;
      rx_cnt_reg  <= `SFL_CNT_RST;
      st_reg      <= 5'h00;
      irq_reg     <= 1'b0;
    end else if (ce) begin
      tx_cnt_reg  <= tx_cnt_next;
      rx_cnt_reg  <= rx_cnt_next;
      st_reg      <= st_next;
      irq_reg     <= |(status & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // fifo arrays
  // ----------------------------------------------------------------
  // low lanes first: lane i lands at write pointer plus i
  always @(posedge pclk) begin
    if (ce) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (tx_push && (i < nbytes))
          tx_mem[tx_wp_reg + i[AW-1:0]] <= pwdata[8*i +: 8];
      end
      if (rx_put)
        rx_mem[rx_wp_reg] <= rx_byte;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign tx_byte     = tx_byte_reg;
  assign tx_byte_vld = tx_vld_reg;
  assign irq         = irq_reg;

endmodule // sfl_top

//--- tb/sfl_props.sv
// concurrent checks on the ports of the fifo level slice
`timescale 1ns/1ps
`include "sfl_regs.vh"
module sfl_props #(
  parameter AW = 4
) (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        tx_pop,
  input wire [7:0]  tx_byte,
  input wire        tx_byte_vld,
  input wire        irq
);
  localparam int DEPTH = 1 << AW;
  // a completed read, when prdata is valid
  wire rd_done = psel && penable && pready && !pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // bus timing, irq after reset, tx port, count and mask fields
  // ----------------------------------------------------------------
  setup_wait_a: assert property (psel && !penable && ce |=> !pready)
    else $error("pready high in first access cycle");
  one_wait_a: assert property (psel && penable && !pready && ce |=> pready)
    else $error("more than one wait state");
  pready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("pready longer than one cycle");
  irq_reset_a: assert property ($rose(presetn) |-> ##[1:3] irq)
    else $error("irq not raised by rx empty after reset");
  pop_cause_a: assert property (tx_byte_vld && $past(ce) |-> $past(tx_pop))
    else $error("tx byte valid without a pop");
  byte_hold_a: assert property (!tx_byte_vld |-> $stable(tx_byte))
    else $error("tx byte changed without valid");
  count_range_a: assert property (rd_done && paddr == `SFL_COUNT_OFS |->
    prdata[31:16] <= DEPTH && prdata[15:0] <= DEPTH) else $error("count beyond depth");
  txport_zero_a: assert property (rd_done && paddr == `SFL_TXDATA_OFS |->
    prdata == 32'h00000000) else $error("tx port read not zero");
  mask_bits_a: assert property (rd_done && paddr == `SFL_MASK_OFS |->
    (prdata & ~`SFL_MASK_RW) == 32'h00000000) else $error("reserved mask bit set");
endmodule // sfl_props
bind sfl_top sfl_props #(.AW(AW)) u_props (.pclk(pclk), .presetn(presetn), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .tx_pop(tx_pop), .tx_byte(tx_byte), .tx_byte_vld(tx_byte_vld),
  .irq(irq));

//--- tb/sfl_eng_model.sv
// behavioural model of the shift engine on the fifo far side
`timescale 1ns/1ps
module sfl_eng_model (
  input  wire        pclk,
  input  wire [7:0]  tx_byte,
  input  wire        tx_byte_vld,
  output logic       tx_pop = 1'b0,
  output logic       rx_push = 1'b0,
  output logic [7:0] rx_byte = 8'h00
);
  logic [7:0] got[$];
  // collect every byte handed out by the tx fifo
  always @(posedge pclk) begin
    if (tx_byte_vld) got.push_back(tx_byte);
  end
  // pop n bytes back to back
  task pop(input int n);
    repeat (n) @(posedge pclk) tx_pop <= 1'b1;
    @(posedge pclk) tx_pop <= 1'b0;
  endtask
  // push one byte; the idle data line then shows the inverse
  task push(input logic [7:0] b);
    @(posedge pclk) rx_push <= 1'b1;
    rx_byte <= b;
    @(posedge pclk) rx_push <= 1'b0;
    rx_byte <= ~b;
  endtask
endmodule // sfl_eng_model

//--- tb/tb_top.sv
// self-checking bench of the fifo level register slice
`timescale 1ns/1ps
`include "sfl_regs.vh"
module tb_top;
  localparam logic [7:0] ST = `SFL_STATUS_OFS, CN = `SFL_COUNT_OFS, MK = `SFL_MASK_OFS;
  localparam logic [7:0] TG = `SFL_TRIG_OFS, TX = `SFL_TXDATA_OFS, RX = `SFL_RXDATA_OFS;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic        ce = 1;
  logic [7:0]  paddr = 0, tx_byte, rx_byte;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  pstrb = 0;
  logic [2:0]  ev = 0;
  logic        pready, pslverr, tx_pop, tx_byte_vld, rx_push, irq;
  int          n_errors = 0, num_checks = 0;
  always #50 pclk = ~pclk;
  sfl_top DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_pop(tx_pop), .tx_byte(tx_byte),
    .tx_byte_vld(tx_byte_vld), .rx_push(rx_push), .rx_byte(rx_byte), .xfer_done(ev[0]),
    .dma_done(ev[1]), .prog_err_flag(ev[2]), .irq(irq));
  sfl_eng_model ENG (.pclk(pclk), .tx_byte(tx_byte), .tx_byte_vld(tx_byte_vld),
    .tx_pop(tx_pop), .rx_push(rx_push), .rx_byte(rx_byte));
  // ----------------------------------------------------------------
  // bus and compare helpers
  // ----------------------------------------------------------------
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] v);
    num_checks++;
    if (v !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, v);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d, 4'hF);
  endtask
  task rc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(0, a, 0, 4'h0);
    chk(nm, e, rd & m);
  endtask
  task settle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset();
    rc("mask rst", MK, 32'hFFFFFFFF, `SFL_MASK_RST);
    rc("trig rst", TG, 32'hFFFFFFFF, 32'h0);
    rc("count rst", CN, 32'hFFFFFFFF, 32'h0);
    rc("tx port rd", TX, 32'hFFFFFFFF, 32'h0);
    chk("irq rx empty", 1, irq);
    rc("unmapped", 8'h30, 32'hFFFFFFFF, 32'h0);
    chk("slverr", 1, err);
    wr(MK, 32'hFFFFFFFF);
    rc("mask rw", MK, 32'hFFFFFFFF, `SFL_MASK_RW);
  endtask
  task automatic t_events();
    int b[3] = '{`SFL_B_XFER_DONE, `SFL_B_DMA_DONE, `SFL_B_PROG_ERR};
    for (int i = 0; i < 3; i++) begin
      wr(MK, 32'h0);
      @(posedge pclk) ev <= 3'b001 << i;
      @(posedge pclk) ev <= 3'b000;
      settle(3);
      chk("irq masked", 0, irq);
      wr(MK, 32'h1 << b[i]);
      settle(3);
      chk("irq event", 1, irq);
      wr(ST, 32'h1 << b[i]);
      settle(3);
      chk("irq cleared", 0, irq);
    end
  endtask
  task automatic t_tx();
    logic [31:0] dv[3] = '{32'h000000A1, 32'h0000B3B2, 32'hC7C6C5C4};
    logic [3:0]  sv[3] = '{4'h1, 4'h3, 4'hF};
    logic [7:0]  eb[7] = '{8'hA1, 8'hB2, 8'hB3, 8'hC4, 8'hC5, 8'hC6, 8'hC7};
    int          cv[3] = '{1, 3, 7};
    for (int i = 0; i < 3; i++) begin
      apb(1, TX, dv[i], sv[i]);
      rc("tx count", CN, 32'hFFFFFFFF, cv[i]);
    end
    ENG.pop(7);
    settle(2);
    chk("popped", 7, ENG.got.size());
    for (int i = 0; i < 7; i++) chk("tx byte", eb[i], ENG.got[i]);
    ENG.got.delete();
    rc("tx drained", CN, 32'hFFFFFFFF, 32'h0);
  endtask
  task t_ovf();
    repeat (4) wr(TX, 32'h11223344);
    rc("tx full", ST, 32'h104, 32'h100);
    wr(TX, 32'h55667788);
    rc("tx ovf", ST, 32'h4, 32'h4);
    rc("count kept", CN, 32'hFFFFFFFF, 32'h10);
    wr(MK, 32'h4);
    settle(2);
    chk("irq ovf", 1, irq);
    wr(ST, 32'h4);
    rc("ovf clr", ST, 32'h4, 32'h0);
    ENG.pop(16);
    settle(2);
    ENG.got.delete();
  endtask
  task t_levels();
    wr(TG, 32'h00020002);
    rc("tx req empty", ST, 32'h400, 32'h400);
    apb(1, TX, 32'h0000EEDD, 4'h3);
    rc("tx req at", ST, 32'h400, 32'h400);
    apb(1, TX, 32'h000000CC, 4'h1);
    rc("tx req above", ST, 32'h400, 32'h0);
    ENG.push(8'h5A);
    rc("rx req below", ST, 32'h4000, 32'h0);
    ENG.push(8'hA5);
    rc("rx req at", ST, 32'h4000, 32'h4000);
    rc("rx count", CN, 32'hFFFFFFFF, 32'h00020003);
    wr(TG, 32'h0);
    rc("req off", ST, 32'h4400, 32'h0);
    rc("rx data", RX, 32'hFF, 32'h5A);
    rc("rx data", RX, 32'hFF, 32'hA5);
    rc("rx empty rd", RX, 32'hFF, 32'h0);
    rc("rx udf", ST, 32'h8, 32'h8);
    ENG.pop(3);
  endtask
  task automatic t_rxfull();
    repeat (17) ENG.push(8'h96);
    rc("rx full", ST, 32'h3000, 32'h1000);
    rc("rx kept", CN, 32'hFFFF0000, 32'h00100000);
    wr(MK, 32'h1000);
    settle(2);
    chk("irq rx full", 1, irq);
    repeat (16) rc("rx drain", RX, 32'hFF, 32'h96);
    rc("rx empty", ST, 32'h3000, 32'h2000);
  endtask
  task automatic t_freeze();
    @(posedge pclk) ce <= 1'b0;
    ENG.push(8'h3C);
    @(posedge pclk) ev <= 3'b001;
    @(posedge pclk) ev <= 3'b000;
    @(posedge pclk) ce <= 1'b1;
    rc("frozen rx", CN, 32'hFFFF0000, 32'h0);
    rc("frozen ev", ST, 32'h1, 32'h0);
  endtask
  task stop_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_events();
    t_tx();
    t_ovf();
    t_levels();
    t_rxfull();
    t_freeze();
    stop_test();
  end
  // watchdog against a hung handshake
  initial begin
    #500000;
    n_errors++;
    stop_test();
  end
endmodule // tb_top
